/* asc_pkg.sv */
// Purpose: constants and types for the serial control block
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes:   field positions follow the control register layout
package asc_pkg;
   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [7:0] OFF_CTRL_A0 = 8'h00;
   localparam logic [7:0] OFF_CTRL_A1 = 8'h04;
   localparam logic [7:0] OFF_CTRL_B  = 8'h08;
   localparam logic [7:0] OFF_EXT     = 8'h0c;
   localparam logic [7:0] OFF_TXDATA  = 8'h10;
   localparam logic [7:0] OFF_RXDATA  = 8'h14;
   localparam logic [7:0] OFF_STAT    = 8'h18;
   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int BIT_MPE   = 7;
   localparam int BIT_RE    = 6;
   localparam int BIT_TE    = 5;
   localparam int BIT_RTS   = 4;
   localparam int BIT_MPB   = 3;
   localparam int BIT_DLEN  = 2;
   localparam int BIT_PAR   = 1;
   localparam int BIT_STOP  = 0;
   localparam int BIT_TXMPB = 7;
   localparam int BIT_MPSEL = 6;
   localparam int BIT_OVERRUN_FLAG  = 3;
   localparam int BIT_FE    = 2;
   localparam int BIT_PE    = 1;
   localparam int BIT_BRK   = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] EXT_RST  = 4'h0;
   // ***********************************************************
   // timing and sizes
   // ***********************************************************
   localparam int BAUD_DIV_DEF = 16;
   localparam int FIFO_DEPTH   = 8;
   // ***********************************************************
   // types
   // ***********************************************************
   typedef enum logic [1:0] {
      ASC_IDLE  = 2'b00,
      ASC_START = 2'b01,
      ASC_SHIFT = 2'b10
   } asc_ser_type;
   typedef struct packed {
      logic dlen;
      logic par;
      logic stop;
      logic mp;
   } asc_fmt_type;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } asc_apb_req_type;
endpackage

/* asc_serial_ctrl.sv */
// Purpose: serial control register A block with one serial engine
// Assumes: all inputs synchronous to mclk, rxd idles high
// Notes:   fifo depth must be a power of two
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps

// ***********************************************************
// fifo
// ***********************************************************
module asc_fifo #(
   parameter int W = 8,
   parameter int D = asc_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  logic         mclk,
   input  logic         rst_n,
   // fill side
   input  logic         in_valid,
   output logic         in_ready,
   input  logic [W-1:0] in_data,
   // drain side
   output logic         out_valid,
   input  logic         out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } asc_fifo_st_type;
   asc_fifo_st_type q;
   asc_fifo_st_type d;
   logic [AW:0]     used;

   assign used      = q.wp - q.rp;
   assign in_ready  = used != (AW+1)'(D);
   assign out_valid = used != '0;
   assign out_data  = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid && in_ready) begin
         d.mem[q.wp[AW-1:0]] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ***********************************************************
// control block
// ***********************************************************
// Function
// - transmit enable clears on reset and while io halt is active
// - disabling transmit leaves the transmit empty flag as it was
// - rts pin carries rts while configuration bit 4 is zero
// - channel 0 bit 4 is a plain output bit driving rts
// - channel 1 bit 4 picks dma end output (1) or serial clock (0)
// - rts bit and channel 1 pin select reset to zero
// - with multiprocessor mode, channel 0 bit 3 reads last received mp bit (channel 1 bit 3 reads zero)
// - writing zero to channel 0 bit 3 clears all four receive error flags
// - bit 3 readback is zero after reset
// - bit 2 data length, bit 1 parity, bit 0 stop bits
// - frame is start, data, optional parity, one or two stops
// - mp bit is added to frames only when mp select is one
// - with wakeup, frames with mp bit zero leave flags alone
module asc_serial_ctrl #(
   parameter int BAUD_DIV = asc_pkg::BAUD_DIV_DEF
) (
   // clock and reset
   input  logic                    mclk,
   input  logic                    rst_n,
   // apb
   input  asc_pkg::asc_apb_req_type apb_req,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // system
   input  logic                    io_halt_mode,
   input  logic                    sys_cfg_csio_sel,
   input  logic                    clocked_serial_tx_pin,
   input  logic                    dma0_end_strobe,
   input  logic                    ch1_serial_clock,
   // pins
   input  logic                    rxd,
   output logic                    txd,
   output logic                    rts_txs_pin,
   output logic                    ch1_pin_out,
   output logic                    tx_empty_flag
);
   localparam logic [15:0] BFULL = 16'(BAUD_DIV - 1);
   localparam logic [15:0] BHALF = 16'(BAUD_DIV / 2 - 1);

   typedef struct packed {
      logic [7:0]          ctrl0;
      logic [7:0]          ctrl1;
      logic [7:0]          ctrlb;
      logic [3:0]          ext;
      logic                rx_full;
      logic [7:0]          rx_data;
      logic                last_mpb;
      logic [31:0]         prdata;
      logic                rts_pin;
      logic                ch1_pin;
      asc_pkg::asc_ser_type tx_st;
      logic [12:0]         tx_sh;
      logic [3:0]          tx_cnt;
      logic [15:0]         tx_div;
      asc_pkg::asc_fmt_type tx_fmt;
      asc_pkg::asc_ser_type rx_st;
      logic [12:0]         rx_sh;
      logic [3:0]          rx_cnt;
      logic [15:0]         rx_div;
      asc_pkg::asc_fmt_type rx_fmt;
   } asc_st_type;

   asc_st_type q;
   asc_st_type d;

   logic                 acc;
   logic                 wr;
   logic                 rd_rx;
   logic                 wr_tx;
   logic                 hit;
   logic                 f_valid;
   logic                 f_ready;
   logic                 f_pop;
   logic [8:0]           f_data;
   logic                 tx_start;
   logic                 rx_done;
   logic                 rx_mpb;
   asc_pkg::asc_fmt_type fmt;

   // ***********************************************************
   // frame helpers
   // ***********************************************************
   function automatic logic [12:0] asc_frame(
      input asc_pkg::asc_fmt_type f,
      input logic [7:0]           dt,
      input logic                 m);
      logic [12:0] v;
      logic [3:0]  p;
      v = '1;
      v[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < 7 || f.dlen) begin
            v[i+1] = dt[i];
         end
      end
      p = f.dlen ? 4'h9 : 4'h8;
      if (f.par) begin
         v[p] = ^(dt & (f.dlen ? 8'hff : 8'h7f));
         p = p + 4'h1;
      end
      if (f.mp) begin
         v[p] = m;
      end
      return v;
   endfunction

   function automatic logic [3:0] asc_len(input asc_pkg::asc_fmt_type f);
      return 4'h9 + {3'b0, f.dlen} + {3'b0, f.par} + {3'b0, f.mp}
             + {3'b0, f.stop};
   endfunction

   // ***********************************************************
   // apb decode
   // ***********************************************************
   assign acc   = apb_req.psel && apb_req.penable;
   assign wr    = acc && apb_req.pwrite && pready;
   assign rd_rx = acc && !apb_req.pwrite
                  && apb_req.paddr == asc_pkg::OFF_RXDATA;
   assign wr_tx = acc && apb_req.pwrite
                  && apb_req.paddr == asc_pkg::OFF_TXDATA;
   assign hit   = apb_req.paddr inside {asc_pkg::OFF_CTRL_A0,
                  asc_pkg::OFF_CTRL_A1, asc_pkg::OFF_CTRL_B,
                  asc_pkg::OFF_EXT, asc_pkg::OFF_TXDATA,
                  asc_pkg::OFF_RXDATA, asc_pkg::OFF_STAT};
   assign pready  = !(wr_tx && !f_ready);
   assign pslverr = acc && !hit;
   assign prdata  = q.prdata;

   // format from channel 0 live bits, mp select from ctrl b
   assign fmt.dlen = q.ctrl0[asc_pkg::BIT_DLEN];
   assign fmt.par  = q.ctrl0[asc_pkg::BIT_PAR];
   assign fmt.stop = q.ctrl0[asc_pkg::BIT_STOP];
   assign fmt.mp   = q.ctrlb[asc_pkg::BIT_MPSEL];

   // ***********************************************************
   // transmit fifo
   // ***********************************************************
   asc_fifo #(.W(9), .D(asc_pkg::FIFO_DEPTH)) u_txf (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (wr_tx),
      .in_ready  (f_ready),
      .in_data   ({q.ctrlb[asc_pkg::BIT_TXMPB],
                   apb_req.pwdata[7:0]}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   assign tx_start = q.tx_st == asc_pkg::ASC_IDLE && f_valid
                     && q.ctrl0[asc_pkg::BIT_TE];
   assign f_pop    = tx_start;
   assign tx_empty_flag = f_ready;
   assign txd         = q.tx_sh[0];
   assign rts_txs_pin = q.rts_pin;
   assign ch1_pin_out = q.ch1_pin;

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      logic [12:0] nsh;
      logic [7:0]  rdat;
      logic [3:0]  pi;
      logic        pbit;
      logic        stp;
      logic        full_eff;
      d        = q;
      nsh      = q.rx_sh;
      rdat     = 8'h00;
      pi       = 4'h0;
      pbit     = 1'b0;
      stp      = 1'b1;
      full_eff = q.rx_full && !rd_rx;
      rx_done  = 1'b0;
      rx_mpb   = 1'b1;
      // register writes
      if (wr) begin
         case (apb_req.paddr)
            asc_pkg::OFF_CTRL_A0: begin
               d.ctrl0 = apb_req.pwdata[7:0];
               if (!apb_req.pwdata[asc_pkg::BIT_MPB]) begin
                  d.ext = '0;
               end
            end
            asc_pkg::OFF_CTRL_A1: d.ctrl1 = apb_req.pwdata[7:0];
            asc_pkg::OFF_CTRL_B:  d.ctrlb = apb_req.pwdata[7:0];
            default: ;
         endcase
      end
      if (rd_rx) begin
         d.rx_full = 1'b0;
      end
      if (io_halt_mode) begin
         d.ctrl0[asc_pkg::BIT_TE] = 1'b0;
         d.ctrl1[asc_pkg::BIT_TE] = 1'b0;
      end
      // read data captured in the setup phase
      if (apb_req.psel && !apb_req.penable) begin
         case (apb_req.paddr)
            asc_pkg::OFF_CTRL_A0: d.prdata = {24'h0000_00, q.ctrl0[7:4],
               q.ctrlb[asc_pkg::BIT_MPSEL] && q.last_mpb,
               q.ctrl0[2:0]};
            asc_pkg::OFF_CTRL_A1: d.prdata = {24'h0000_00, q.ctrl1[7:4],
               1'b0, q.ctrl1[2:0]};
            asc_pkg::OFF_CTRL_B:  d.prdata = {24'h0000_00, q.ctrlb};
            asc_pkg::OFF_EXT:     d.prdata = {28'h000_0000, q.ext};
            asc_pkg::OFF_RXDATA:  d.prdata = {24'h0000_00, q.rx_data};
            asc_pkg::OFF_STAT:    d.prdata = {29'h0000_0000,
               q.tx_st != asc_pkg::ASC_IDLE, q.rx_full, f_ready};
            default:              d.prdata = 32'h0000_0000;
         endcase
      end
      // pin functions
      d.rts_pin = sys_cfg_csio_sel ? clocked_serial_tx_pin
                                   : q.ctrl0[asc_pkg::BIT_RTS];
      d.ch1_pin = q.ctrl1[asc_pkg::BIT_RTS] ? dma0_end_strobe
                                            : ch1_serial_clock;
      // transmitter
      case (q.tx_st)
         asc_pkg::ASC_IDLE: begin
            d.tx_sh = '1;
            if (tx_start) begin
               d.tx_fmt = fmt;
               d.tx_sh  = asc_frame(fmt, f_data[7:0], f_data[8]);
               d.tx_cnt = asc_len(fmt) - 4'h1;
               d.tx_div = BFULL;
               d.tx_st  = asc_pkg::ASC_SHIFT;
            end
         end
         asc_pkg::ASC_SHIFT: begin
            d.tx_div = q.tx_div - 16'h0001;
            if (q.tx_div == 16'h0000) begin
               d.tx_div = BFULL;
               d.tx_sh  = {1'b1, q.tx_sh[12:1]};
               d.tx_cnt = q.tx_cnt - 4'h1;
               if (q.tx_cnt == 4'h0) begin
                  d.tx_st = asc_pkg::ASC_IDLE;
               end
            end
         end
         default: d.tx_st = asc_pkg::ASC_IDLE;
      endcase
      if (!d.ctrl0[asc_pkg::BIT_TE]) begin
         d.tx_st = asc_pkg::ASC_IDLE;
         d.tx_sh = '1;
      end
      // receiver
      case (q.rx_st)
         asc_pkg::ASC_IDLE: begin
            if (q.ctrl0[asc_pkg::BIT_RE] && !rxd) begin
               d.rx_div = BHALF;
               d.rx_st  = asc_pkg::ASC_START;
            end
         end
         asc_pkg::ASC_START: begin
            d.rx_div = q.rx_div - 16'h0001;
            if (q.rx_div == 16'h0000) begin
               d.rx_st  = rxd ? asc_pkg::ASC_IDLE : asc_pkg::ASC_SHIFT;
               d.rx_fmt = fmt;
               d.rx_cnt = 4'h0;
               d.rx_div = BFULL;
            end
         end
         asc_pkg::ASC_SHIFT: begin
            d.rx_div = q.rx_div - 16'h0001;
            if (q.rx_div == 16'h0000) begin
               d.rx_div = BFULL;
               nsh[q.rx_cnt] = rxd;
               d.rx_sh  = nsh;
               d.rx_cnt = q.rx_cnt + 4'h1;
               if (q.rx_cnt == asc_len(q.rx_fmt) - 4'h2) begin
                  rx_done = 1'b1;
                  d.rx_st = asc_pkg::ASC_IDLE;
               end
            end
         end
         default: d.rx_st = asc_pkg::ASC_IDLE;
      endcase
      if (!q.ctrl0[asc_pkg::BIT_RE]) begin
         d.rx_st = asc_pkg::ASC_IDLE;
      end
      // decode a finished frame
      rdat = q.rx_fmt.dlen ? nsh[7:0] : {1'b0, nsh[6:0]};
      pi   = q.rx_fmt.dlen ? 4'h8 : 4'h7;
      pbit = nsh[pi];
      pi   = pi + {3'b0, q.rx_fmt.par};
      if (q.rx_fmt.mp) begin
         rx_mpb = nsh[pi];
         pi     = pi + 4'h1;
      end
      stp = nsh[pi];
      if (rx_done) begin
         d.last_mpb = rx_mpb;
         if (!(q.rx_fmt.mp && q.ctrl0[asc_pkg::BIT_MPE]
               && !rx_mpb)) begin
            if (full_eff) begin
               d.ext[asc_pkg::BIT_OVERRUN_FLAG] = 1'b1;
            end else begin
               d.rx_data = rdat;
               d.rx_full = 1'b1;
            end
            if (!stp) begin
               d.ext[asc_pkg::BIT_FE] = 1'b1;
            end
            if (q.rx_fmt.par && pbit != ^rdat) begin
               d.ext[asc_pkg::BIT_PE] = 1'b1;
            end
            if (!stp && rdat == 8'h00) begin
               d.ext[asc_pkg::BIT_BRK] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.ctrl0 <= asc_pkg::CTRL_RST;
         q.ctrl1 <= asc_pkg::CTRL_RST;
         q.ctrlb <= asc_pkg::CTRL_RST;
         q.ext   <= asc_pkg::EXT_RST;
         q.tx_sh <= '1;
      end else begin
         q <= d;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_te_halt_clear: assert property (io_halt_mode |=>
      !q.ctrl0[asc_pkg::BIT_TE] && !q.ctrl1[asc_pkg::BIT_TE])
      else $error("transmit enable not cleared by halt");
   a_tx_empty_hold: assert property (
      !q.ctrl0[asc_pkg::BIT_TE] && !wr_tx |=> $stable(tx_empty_flag))
      else $error("empty flag moved while disabled");
   a_rts_pin_func: assert property (!sys_cfg_csio_sel |=>
      rts_txs_pin == $past(q.ctrl0[asc_pkg::BIT_RTS]))
      else $error("rts pin not following rts bit");
   a_rts_plain_bit: assert property (
      wr && apb_req.paddr == asc_pkg::OFF_CTRL_A0 |=>
      q.ctrl0[asc_pkg::BIT_RTS] == $past(apb_req.pwdata[4])
      && $stable(q.rx_full))
      else $error("rts bit write wrong or had side effect");
   a_ch1_pin_sel: assert property (1'b1 |=>
      ch1_pin_out == ($past(q.ctrl1[asc_pkg::BIT_RTS])
      ? $past(dma0_end_strobe) : $past(ch1_serial_clock)))
      else $error("channel 1 pin select wrong");
   a_last_mp_bit_readback_read_back: assert property (
      apb_req.psel && !apb_req.penable
      && apb_req.paddr == asc_pkg::OFF_CTRL_A0 |=>
      prdata[3] == $past(q.ctrlb[asc_pkg::BIT_MPSEL] && q.last_mpb))
      else $error("mp bit readback wrong");
   a_efr_clear: assert property (
      wr && apb_req.paddr == asc_pkg::OFF_CTRL_A0
      && !apb_req.pwdata[3] && !rx_done |=> q.ext == 4'h0)
      else $error("error flags not cleared");
   a_start_bit_low: assert property (tx_start
      && !io_halt_mode |=> !txd [*8])
      else $error("start bit not low");
   a_wake_ignore: assert property (rx_done
      && q.rx_fmt.mp && q.ctrl0[asc_pkg::BIT_MPE] && !rx_mpb |=>
      $stable(q.rx_data) && (q.ext & ~$past(q.ext)) == 4'h0)
      else $error("ignored frame touched flags");
   a_fmt_hold: assert property (
      q.tx_st == asc_pkg::ASC_SHIFT && q.tx_div != 16'h0000 |=>
      $stable(q.tx_fmt) && $stable(q.tx_cnt))
      else $error("format changed mid frame");
endmodule

/* asc_remote_model.sv */
// Purpose: remote serial device on the far side of the line
// Assumes: line idles high, both ends use the same format
// Notes:   format is {data length, parity, stop bits, mp bit}
`timescale 1ns/100ps
module asc_remote_model #(
   parameter int BAUD = 8
) (
   // clock
   input  logic       mclk,
   // line
   output logic       rxd,
   input  logic       txd,
   // format and last frame seen
   input  logic [3:0] fmt,
   output logic [7:0] got_data,
   output logic       got_ok,
   output logic [7:0] got_cnt
);
   // ***********************************************************
   // receive and send
   // ***********************************************************
   initial begin
      rxd      = 1'b1;
      got_data = 8'h00;
      got_ok   = 1'b0;
      got_cnt  = 8'h00;
   end
   always begin : rx_side
      logic [12:0] b;
      logic [7:0]  d;
      int          n;
      int          k;
      @(negedge txd);
      n = 8 + int'(fmt[3]) + int'(fmt[2]) + int'(fmt[1]) + int'(fmt[0]);
      repeat (BAUD / 2) @(posedge mclk);
      for (int i = 0; i <= n; i++) begin
         b[i] = txd;
         if (i < n) repeat (BAUD) @(posedge mclk);
      end
      d = b[8:1] & (fmt[3] ? 8'hff : 8'h7f);
      k = fmt[3] ? 9 : 8;
      // start low, parity even, stops high
      got_ok = ~b[0] & (~fmt[2] | (b[k] == ^d)) & b[n] & (b[n-1] | ~fmt[1]);
      got_data = d;
      got_cnt = got_cnt + 8'h01;
   end
   task automatic send(input logic [7:0] d, input logic [3:0] f,
                       input logic multiproc_flag_bit, input logic bad);
      logic [12:0] b;
      int          k;
      b = '1;
      b[0] = 1'b0;
      k = 1;
      for (int i = 0; i < 7 + int'(f[3]); i++) begin
         b[k] = d[i];
         k++;
      end
      if (f[2]) begin
         b[k] = ^(d & (f[3] ? 8'hff : 8'h7f));
         k++;
      end
      if (f[0]) begin
         b[k] = multiproc_flag_bit;
         k++;
      end
      b[k] = ~bad;
      for (int i = 0; i <= k + int'(f[1]); i++) begin
         rxd <= b[i];
         repeat (BAUD) @(posedge mclk);
      end
      rxd <= 1'b1;
   endtask
endmodule

/* async_serial_control_a_tb_top.sv */
// Purpose: self-checking bench for the serial control block
// Assumes: baud divider shortened to 8 cycles
// Notes:   registers through apb, pins watched directly
`timescale 1ns/100ps
module async_serial_control_a_tb_top;
   localparam int         BAUD = 8;
   localparam logic [7:0] A0   = asc_pkg::OFF_CTRL_A0;
   localparam logic [7:0] A1   = asc_pkg::OFF_CTRL_A1;
   localparam logic [7:0] EXT  = asc_pkg::OFF_EXT;
   localparam logic [7:0] TXD  = asc_pkg::OFF_TXDATA;
   localparam logic [7:0] RXD  = asc_pkg::OFF_RXDATA;
   localparam logic [7:0] STA  = asc_pkg::OFF_STAT;
   logic                     mclk, rst_n, pready, pslverr, perr;
   logic                     halt, csio, cstx, dend, c1clk;
   logic                     rxd, txd, rts, c1pin, txe, gok;
   logic [31:0]              prdata;
   logic [7:0]               q, gd, gc, c;
   logic [3:0]               fmt;
   asc_pkg::asc_apb_req_type req;
   int                       failures, compares;
   int                       waits;
   asc_serial_ctrl #(.BAUD_DIV(BAUD)) dut_u (.mclk(mclk), .rst_n(rst_n),
      .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .io_halt_mode(halt), .sys_cfg_csio_sel(csio),
      .clocked_serial_tx_pin(cstx), .dma0_end_strobe(dend),
      .ch1_serial_clock(c1clk), .rxd(rxd), .txd(txd), .rts_txs_pin(rts),
      .ch1_pin_out(c1pin), .tx_empty_flag(txe));
   asc_remote_model #(.BAUD(BAUD)) model_u (.mclk(mclk), .rxd(rxd),
      .txd(txd), .fmt(fmt), .got_data(gd), .got_ok(gok), .got_cnt(gc));
   always #4 mclk = ~mclk;
   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic final_report();
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] seen,
                      input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      waits = n;
      if (n >= 200) begin
         failures++;
         final_report();
      end
      q = prdata[7:0];
      perr = pslverr;
      req <= '0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask
   task automatic wait_cnt(input logic [7:0] t);
      int n;
      n = 0;
      while (gc !== t && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000) begin
         failures++;
         final_report();
      end
   endtask
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_reset();
      rd(A0);
      chk("ctrl_a0", q & 8'hf7, 8'h00);
      rd(A1);
      chk("ctrl_a1", q, 8'h00);
      chk("pins", {5'h00, rts, c1pin, txe}, 8'h01);
      rd(8'h1c);
      chk("unmapped", {7'h00, perr}, 8'h01);
   endtask
   task automatic t_pins();
      wr(A0, 8'h10);
      repeat (2) @(posedge mclk);
      chk("rts on", {7'h00, rts}, 8'h01);
      rd(EXT);
      chk("ext", q, 8'h00);
      csio <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("txs", {7'h00, rts}, 8'h00);
      cstx <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("txs high", {7'h00, rts}, 8'h01);
      csio <= 1'b0;
      dend <= 1'b1;
      wr(A1, 8'h10);
      repeat (2) @(posedge mclk);
      chk("dma end", {7'h00, c1pin}, 8'h01);
      wr(A1, 8'h00);
      wr(A0, 8'h00);
      repeat (2) @(posedge mclk);
      chk("ch1 clk", {7'h00, c1pin}, 8'h00);
      c1clk <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("ch1 clk hi", {7'h00, c1pin}, 8'h01);
      chk("rts off", {7'h00, rts}, 8'h00);
   endtask
   task automatic t_tx();
      for (int f = 0; f < 8; f++) begin
         fmt <= {3'(f), 1'b0};
         c = gc;
         wr(A0, {5'h04, 3'(f)});
         wr(TXD, 8'ha5);
         wr(A0, {5'h04, ~3'(f)});
         wait_cnt(c + 8'h01);
         chk("tx data", gd, f[2] ? 8'ha5 : 8'h25);
         chk("tx frame", {7'h00, gok}, 8'h01);
      end
   endtask
   task automatic t_fifo();
      wr(A0, 8'h04);
      fmt <= 4'h8;
      c = gc;
      for (int i = 0; i < 8; i++) wr(TXD, 8'(i));
      chk("fifo full", {7'h00, txe}, 8'h00);
      halt <= 1'b1;
      wr(A0, 8'h24);
      rd(A0);
      chk("te halt", q & 8'h20, 8'h00);
      chk("empty held", {7'h00, txe}, 8'h00);
      halt <= 1'b0;
      wr(A0, 8'h24);
      wr(TXD, 8'h08);
      wr(TXD, 8'h09);
      chk("stall", {7'h00, waits > 1}, 8'h01);
      wait_cnt(c + 8'h0a);
      chk("drain", gd, 8'h09);
      chk("fifo room", {7'h00, txe}, 8'h01);
   endtask
   task automatic t_rx_err();
      wr(A0, 8'h44);
      model_u.send(8'h5a, 4'h8, 1'b0, 1'b1);
      repeat (2 * BAUD) @(posedge mclk);
      rd(EXT);
      chk("framing", q, 8'h04);
      wr(A0, 8'h4e);
      model_u.send(8'h00, 4'h8, 1'b0, 1'b0);
      repeat (2 * BAUD) @(posedge mclk);
      wr(A0, 8'h4c);
      model_u.send(8'h00, 4'h8, 1'b0, 1'b1);
      repeat (2 * BAUD) @(posedge mclk);
      rd(EXT);
      chk("all flags", q, 8'h0f);
      rd(RXD);
      chk("rx data", q, 8'h5a);
      wr(A0, 8'h4c);
      rd(EXT);
      chk("no clear", q, 8'h0f);
      wr(A0, 8'h44);
      rd(EXT);
      chk("cleared", q, 8'h00);
   endtask
   task automatic t_mp();
      wr(asc_pkg::OFF_CTRL_B, 8'h40);
      wr(A0, 8'hc4);
      model_u.send(8'h33, 4'h9, 1'b1, 1'b0);
      repeat (2 * BAUD) @(posedge mclk);
      rd(A0);
      chk("mp bit 1", q & 8'h08, 8'h08);
      rd(RXD);
      chk("mp data", q, 8'h33);
      model_u.send(8'h44, 4'h9, 1'b0, 1'b0);
      repeat (2 * BAUD) @(posedge mclk);
      rd(STA);
      chk("no full", q & 8'h02, 8'h00);
      rd(A0);
      chk("mp bit 0", q & 8'h08, 8'h00);
   endtask
   initial begin
      {mclk, rst_n, perr, halt, csio, cstx, dend, c1clk} = '0;
      {failures, compares} = '0;
      {q, c} = '0;
      fmt = 4'h8;
      req = '0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_pins();
      t_tx();
      t_fifo();
      t_rx_err();
      t_mp();
      final_report();
   end
endmodule
